// file: siep_irq.sv
// Interrupt source enables, output mode and persistence filtering
`timescale 1ns/100ps
`include "siep_defs.svh"
module siep_irq
   import siep_pkg::*;
#(
   parameter int DATA_W = 20,
   parameter int CNT_W = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire siep_reg_req_t i_reg,
   input wire logic i_status_read,
   input wire logic i_ls_done,
   input wire logic [DATA_W-1:0] i_ls_data,
   input wire logic [DATA_W-1:0] i_light_upper_limit,
   input wire logic [DATA_W-1:0] i_light_lower_limit,
   input wire logic i_light_irq_enable,
   input wire siep_meas_t i_prox,
   input wire logic i_fifo_afull,
   input wire logic i_ppg_data,
   output logic [7:0] o_reg_rdata,
   output logic o_int_n
);
   // Counter width is tied to the nibble-wide codes
   if (CNT_W != 4 || DATA_W < 1) begin : g_bad_params
      $error("siep_irq: CNT_W must be 4 and DATA_W positive");
   end

   logic [7:0] src_en_ff;
   logic [7:0] persist_ff;
   logic pending_ff;
   logic level_ff;
   logic [CNT_W-1:0] cnt_ff [`SIEP_NUM_SENS];
   logic [7:0] o_reg_rdata_ff;
   logic o_int_n_ff;

   // Register decode
   wire wr_src_en = i_reg.wr && (i_reg.addr == `SIEP_ADDR_SRC_EN);
   wire wr_persist = i_reg.wr && (i_reg.addr == `SIEP_ADDR_PERSIST);
   wire rd_src_en = i_reg.rd && (i_reg.addr == `SIEP_ADDR_SRC_EN);
   wire rd_persist = i_reg.rd && (i_reg.addr == `SIEP_ADDR_PERSIST);
   wire [7:0] rd_mux = rd_src_en ? src_en_ff :
                       rd_persist ? persist_ff : 8'h00;
   // Reserved bits are not stored, so they read back zero
   wire [7:0] nxt_src_en = i_reg.wdata & `SIEP_SRC_EN_MASK;

   wire afull_en = src_en_ff[`SIEP_BIT_AFULL_EN];
   wire ppg_en = src_en_ff[`SIEP_BIT_PPG_EN];
   wire level_mode = src_en_ff[`SIEP_BIT_LEVEL_MODE];
   wire prox_en = src_en_ff[`SIEP_BIT_PROX_EN];

   // Out-of-range detection per sensor
   wire ls_viol = (i_ls_data > i_light_upper_limit) ||
                  (i_ls_data < i_light_lower_limit);
   wire [`SIEP_NUM_SENS-1:0] meas_done = {i_prox.done, i_ls_done};
   wire [`SIEP_NUM_SENS-1:0] meas_viol = {i_prox.viol, ls_viol};
   wire [CNT_W-1:0] code [`SIEP_NUM_SENS];
   assign code[`SIEP_SENS_LIGHT] =
      persist_ff[`SIEP_LIGHT_CNT_HI:`SIEP_LIGHT_CNT_LO];
   assign code[`SIEP_SENS_PROX] =
      persist_ff[`SIEP_PROX_CNT_HI:`SIEP_PROX_CNT_LO];

   logic [`SIEP_NUM_SENS-1:0] sens_evt;
   logic [CNT_W-1:0] nxt_cnt [`SIEP_NUM_SENS];

   genvar g;
   generate
      for (g = 0; g < `SIEP_NUM_SENS; g++) begin : g_persist
         // Counter saturates at the code; every further violation fires
         wire at_code = (cnt_ff[g] >= code[g]);
         assign sens_evt[g] = meas_done[g] && meas_viol[g] &&
                              at_code;
         assign nxt_cnt[g] = !meas_done[g] ? cnt_ff[g] :
                             !meas_viol[g] ? '0 :
                             at_code ? cnt_ff[g] :
                             cnt_ff[g] + 1'b1;
         always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               cnt_ff[g] <= '0;
            end else begin
               cnt_ff[g] <= nxt_cnt[g];
            end
         end
      end
   endgenerate

   // Latched sources; level mode stops all of them latching, and only proximity reaches the pin, through the level
   wire set_afull = i_fifo_afull && afull_en;
   wire set_ppg = i_ppg_data && ppg_en;
   wire set_prox = sens_evt[`SIEP_SENS_PROX] && prox_en;
   wire set_light = sens_evt[`SIEP_SENS_LIGHT] &&
                    i_light_irq_enable;
   wire set_any = !level_mode &&
                  (set_afull || set_ppg || set_prox || set_light);
   // A new event in the clearing cycle wins over the status read
   wire nxt_pending = set_any ||
                      (pending_ff && !i_status_read);

   // Level follows the last proximity result after persistence
   wire nxt_level = !i_prox.done ? level_ff :
                    sens_evt[`SIEP_SENS_PROX] ? 1'b1 :
                    !i_prox.viol ? 1'b0 : level_ff;
   wire int_active = level_mode ? (nxt_level && prox_en) :
                     nxt_pending;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         src_en_ff <= `SIEP_RST_SRC_EN;
         persist_ff <= `SIEP_RST_PERSIST;
      end else begin
         if (wr_src_en) begin
            src_en_ff <= nxt_src_en;
         end
         if (wr_persist) begin
            persist_ff <= i_reg.wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pending_ff <= 1'b0;
         level_ff <= 1'b0;
         o_int_n_ff <= 1'b1;
         o_reg_rdata_ff <= 8'h00;
      end else begin
         pending_ff <= nxt_pending;
         level_ff <= nxt_level;
         o_int_n_ff <= !int_active;
         if (i_reg.rd) begin
            o_reg_rdata_ff <= rd_mux;
         end
      end
   end

   assign o_int_n = o_int_n_ff;
   assign o_reg_rdata = o_reg_rdata_ff;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   AST_AFULL_SETS: assert property (
      !level_mode && i_fifo_afull && afull_en |=> !o_int_n)
      else $error("almost-full event did not raise pin");
   AST_PPG_SETS: assert property (
      !level_mode && i_ppg_data && ppg_en |=> !o_int_n)
      else $error("pulse-sample event did not raise pin");
   // A pin left low by level mode is not a latched event
   AST_LATCH_HOLDS: assert property (
      !o_int_n && !level_mode && !$past(level_mode) &&
      !i_status_read && !i_reg.wr |=> !o_int_n)
      else $error("latched pin dropped without status read");
   AST_READ_CLEARS: assert property (
      !level_mode && i_status_read && !set_any && !i_reg.wr
      |=> o_int_n)
      else $error("status read did not release pin");
   // A mode or enable write retimes the pin once; skip that cycle
   AST_LEVEL_STABLE: assert property (
      level_mode && $stable(src_en_ff) && !i_prox.done && !i_reg.wr
      |=> $stable(o_int_n))
      else $error("level pin changed between measurements");
   AST_OTHERS_MASKED: assert property (
      level_mode && !prox_en && !i_reg.wr |=> o_int_n)
      else $error("pin active in level mode without proximity enable");
   AST_PROX_GATED: assert property (
      !level_mode && !pending_ff && !prox_en && !i_fifo_afull &&
      !i_ppg_data && !i_ls_done |=> o_int_n)
      else $error("disabled proximity source raised pin");
   AST_LIGHT_GATED: assert property (
      !level_mode && !pending_ff && !i_light_irq_enable &&
      !i_fifo_afull && !i_ppg_data && !i_prox.done |=> o_int_n)
      else $error("disabled light source raised pin");
   AST_LS_COUNT: assert property (
      i_ls_done && ls_viol && (cnt_ff[0] < code[0])
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 4'h1)
      else $error("light persistence count did not advance");
   AST_PS_COUNT: assert property (
      i_prox.done && i_prox.viol && (cnt_ff[1] < code[1]) &&
      !wr_persist |=> cnt_ff[1] == $past(cnt_ff[1]) + 4'h1)
      else $error("proximity persistence count did not advance");
   AST_LS_IN_RANGE: assert property (
      i_ls_done && (i_ls_data <= i_light_upper_limit) &&
      (i_ls_data >= i_light_lower_limit) |=> cnt_ff[0] == 4'h0)
      else $error("light count not cleared on in-range result");
   AST_PS_IN_RANGE: assert property (
      i_prox.done && !i_prox.viol |=> cnt_ff[1] == 4'h0)
      else $error("proximity count not cleared on in-range result");
   AST_PS_FIRES: assert property (
      !level_mode && prox_en && i_prox.done && i_prox.viol &&
      (cnt_ff[1] >= code[1]) |=> !o_int_n)
      else $error("proximity run at its count did not raise pin");
   AST_LS_FIRES: assert property (
      !level_mode && i_light_irq_enable && i_ls_done && ls_viol &&
      (cnt_ff[0] >= code[0]) |=> !o_int_n)
      else $error("light run at its count did not raise pin");
   AST_LEVEL_RELEASE: assert property (
      level_mode && i_prox.done && !i_prox.viol |=> o_int_n)
      else $error("in-range result did not release level pin");
   AST_RSVD_ZERO: assert property (
      (src_en_ff & ~`SIEP_SRC_EN_MASK) == 8'h00)
      else $error("reserved enable bits stored");

   // Main scenarios: clear, long run, level toggle, set over clear
   COV_LATCH_CLEAR: cover property (
      !o_int_n && !level_mode ##1 i_status_read ##1 o_int_n);
   COV_PERSIST_16: cover property (
      code[1] == 4'hf && sens_evt[1]);
   COV_LEVEL_TOGGLE: cover property (
      level_mode && !o_int_n ##[1:50] level_mode && o_int_n);
   COV_SET_WINS: cover property (set_any && i_status_read && pending_ff);
endmodule

// file: siep_defs.svh
// Register offsets, field positions and reset values for the irq block
`ifndef SIEP_DEFS_SVH
`define SIEP_DEFS_SVH
`define SIEP_ADDR_SRC_EN 8'h2c
`define SIEP_ADDR_PERSIST 8'h2d
`define SIEP_RST_SRC_EN 8'h00
`define SIEP_RST_PERSIST 8'h00
`define SIEP_SRC_EN_MASK 8'h33
`define SIEP_BIT_AFULL_EN 5
`define SIEP_BIT_PPG_EN 4
`define SIEP_BIT_LEVEL_MODE 1
`define SIEP_BIT_PROX_EN 0
`define SIEP_LIGHT_CNT_HI 7
`define SIEP_LIGHT_CNT_LO 4
`define SIEP_PROX_CNT_HI 3
`define SIEP_PROX_CNT_LO 0
`define SIEP_SENS_LIGHT 0
`define SIEP_SENS_PROX 1
`define SIEP_NUM_SENS 2
`endif

// file: siep_pkg.sv
// Types shared by the irq enable and persistence block
package siep_pkg;
   typedef struct packed {
      logic done;
      logic viol;
   } siep_meas_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } siep_reg_req_t;
endpackage

// file: siep_host_model.sv
// Host stand-in driving register strobes and status reads
`timescale 1ns/100ps
`include "siep_defs.svh"
module siep_host_model
   import siep_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [7:0] i_reg_rdata,
   output siep_reg_req_t o_reg,
   output logic o_status_read
);
   initial begin
      o_reg = '0;
      o_status_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk) o_reg <= '{1'b1, 1'b0, a,
         (a == `SIEP_ADDR_SRC_EN) ? (d & `SIEP_SRC_EN_MASK) : d};
      @(posedge i_ref_clk) o_reg <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk) o_reg <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_ref_clk) o_reg <= '0;
      #1 d = i_reg_rdata;
   endtask
   // Status read releases the latched pin
   task automatic clr();
      @(posedge i_ref_clk) o_status_read <= 1'b1;
      @(posedge i_ref_clk) o_status_read <= 1'b0;
      #1;
   endtask
endmodule

// file: sensor_interrupt_enable_persist_tb.sv
// Self-checking bench for the irq enable and persistence block
`timescale 1ns/100ps
`include "siep_defs.svh"
module sensor_interrupt_enable_persist_tb
   import siep_pkg::*;
;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic ls_done = 1'b0, light_en = 1'b0, afull = 1'b0, ppg = 1'b0;
   logic [19:0] ls_data = 20'h00000;
   logic [19:0] up_lim = 20'h00100, lo_lim = 20'h00010;
   siep_meas_t prox = '0;
   siep_reg_req_t req;
   logic status_rd, int_n;
   logic [7:0] rdata;
   int n_errors = 0, comparisons = 0;
   always #10 i_ref_clk = ~i_ref_clk;
   siep_host_model host_u (.i_ref_clk(i_ref_clk), .i_reg_rdata(rdata),
      .o_reg(req), .o_status_read(status_rd));
   siep_irq dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg(req),
      .i_status_read(status_rd), .i_ls_done(ls_done), .i_ls_data(ls_data),
      .i_light_upper_limit(up_lim), .i_light_lower_limit(lo_lim),
      .i_light_irq_enable(light_en), .i_prox(prox), .i_fifo_afull(afull),
      .i_ppg_data(ppg), .o_reg_rdata(rdata), .o_int_n(int_n));
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic pin(logic e);
      chk("int_n", {7'h00, int_n}, {7'h00, e});
   endtask
   // Kinds: 0 afull, 1 ppg, 2 prox out, 3 prox in, 4 light high,
   // 5 light in, 6 light low
   task automatic ev(int k);
      @(posedge i_ref_clk) begin
         afull <= (k == 0);
         ppg <= (k == 1);
         prox <= '{(k == 2) || (k == 3), k == 2};
         ls_done <= (k > 3);
         ls_data <= k == 4 ? 20'h00200 : k == 5 ? 20'h00050 : 20'h00001;
      end
      // Stale data inverted so nothing reads it by luck
      @(posedge i_ref_clk) begin
         {afull, ppg, ls_done} <= 3'b000;
         prox <= '0;
         ls_data <= ~ls_data;
      end
      #1;
   endtask
   task automatic t_reset();
      logic [7:0] v;
      pin(1'b1);
      host_u.rd(`SIEP_ADDR_SRC_EN, v);
      chk("src_en", v, 8'h00);
      host_u.rd(`SIEP_ADDR_PERSIST, v);
      chk("persist", v, 8'h00);
      host_u.rd(8'h2b, v);
      chk("unmapped", v, 8'h00);
   endtask
   task automatic t_src();
      logic [7:0] m [3] = '{8'h20, 8'h10, 8'h01};
      for (int k = 0; k < 3; k++) begin
         ev(k);
         pin(1'b1);
         host_u.wr(`SIEP_ADDR_SRC_EN, m[k]);
         ev(k);
         pin(1'b0);
         ev(3);
         pin(1'b0);
         host_u.clr();
         pin(1'b1);
         host_u.wr(`SIEP_ADDR_SRC_EN, 8'h00);
      end
   endtask
   task automatic t_persist();
      logic [7:0] v;
      host_u.wr(`SIEP_ADDR_PERSIST, 8'h13);
      host_u.rd(`SIEP_ADDR_PERSIST, v);
      chk("persist", v, 8'h13);
      host_u.wr(`SIEP_ADDR_SRC_EN, 8'h01);
      repeat (3) ev(2);
      ev(3);
      repeat (3) ev(2);
      pin(1'b1);
      ev(2);
      pin(1'b0);
      host_u.clr();
      @(posedge i_ref_clk) light_en <= 1'b1;
      ev(4);
      pin(1'b1);
      ev(6);
      pin(1'b0);
      host_u.clr();
      ev(5);
      ev(4);
      pin(1'b1);
      // Data equal to a limit is still in range
      @(posedge i_ref_clk) up_lim <= 20'h00050;
      ev(5);
      pin(1'b1);
      @(posedge i_ref_clk) up_lim <= 20'h0004f;
      repeat (2) ev(5);
      pin(1'b0);
      host_u.clr();
      @(posedge i_ref_clk) begin
         light_en <= 1'b0;
         up_lim <= 20'h00100;
      end
      ev(4);
      pin(1'b1);
   endtask
   task automatic t_level();
      host_u.wr(`SIEP_ADDR_PERSIST, 8'h00);
      host_u.wr(`SIEP_ADDR_SRC_EN, 8'h33);
      ev(2);
      pin(1'b0);
      host_u.clr();
      pin(1'b0);
      ev(3);
      pin(1'b1);
      @(posedge i_ref_clk) light_en <= 1'b1;
      for (int k = 0; k < 5; k += 2) ev(k == 2 ? 1 : k);
      pin(1'b1);
      host_u.wr(`SIEP_ADDR_PERSIST, 8'h01);
      ev(2);
      pin(1'b1);
      ev(2);
      pin(1'b0);
      host_u.wr(`SIEP_ADDR_SRC_EN, 8'h02);
      ev(0);
      pin(1'b1);
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_src();
      t_persist();
      t_level();
      print_verdict();
   end
   // Whole run is well under two hundred cycles; this is ample margin
   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end
endmodule
